// ===== logic/quad_ddr_flash_read_pkg.sv
// constants for the quad double-rate flash read block
package quad_ddr_flash_read_pkg;
  localparam int          WORD_W          = 16;
  localparam int          NIB_W           = 4;
  localparam int          WADDR_W         = 18;
  localparam int          ADDR_NIBBLES    = 6;
  localparam int          CMD_BITS        = 16;
  localparam logic [7:0]  ENTRY_OPCODE    = 8'hD4;
  localparam logic [15:0] RELEASE_PATTERN = 16'h55AA;
  localparam logic [7:0]  CONFIG_RESET    = 8'h00;
  // address bit positions
  localparam int          ADDR_TOP_BIT    = 23;
  localparam int          WADDR_LO_BIT    = 1;
  localparam int          WADDR_HI_BIT    = 18;
  // mode_config_byte field layout
  localparam int          BURST_HI        = 7;
  localparam int          BURST_LO        = 5;
  localparam int          RANGE_HI        = 4;
  localparam int          RANGE_LO        = 3;
  localparam int          LAT_HI          = 2;
  localparam int          LAT_LO          = 0;
  localparam logic [2:0]  BURST_CONT      = 3'h0;
  localparam logic [2:0]  BURST_WRAP4     = 3'h4;
  localparam logic [2:0]  BURST_WRAP8     = 3'h5;
  localparam logic [2:0]  BURST_WRAP16    = 3'h6;
  localparam logic [2:0]  BURST_WRAP32    = 3'h7;
  localparam logic [1:0]  RANGE_POWER_SAVE = 2'h0;
  localparam logic [2:0]  LAT_MAX_CODE    = 3'h5;
  localparam logic [1:0]  LAST_NIBBLE     = 2'h3;
  localparam logic [4:0]  CMD_CNT_MAX     = 5'h11;
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_Q_ADDR,
    ST_Q_WAIT,
    ST_Q_LAT,
    ST_Q_DATA,
    ST_Q_HALT
  } mode_state_t;
endpackage : quad_ddr_flash_read_pkg

// ===== logic/quad_ddr_flash_read.sv
// quad double-rate read mode of a serial flash, device side
// Operation
// - in quad mode the four data_io_lines carry address in and data out
// - normal mode samples on rising edges; quad mode uses both clock edges
// - data leaves as 16-bit words; host keeps address bit 0 low
// - quad mode starts at select rise after entry; lasts until release
// - entry accepted in SPI mode 0 or 3; no SPI mode while in quad
// - 24-bit start address latched from four lines on both clock edges
// - while deselected in quad mode all four lines stay inputs
// - address bits 23..19 ignored; only even addresses accepted
// - select rise pauses: outputs float, new address phase needed
// - address xx55AA then select rise after clock low exits quad mode
// - mode configuration byte kept until release, survives pauses
// - config bits 7..5 pick continuous or 4/8/16/32-word wrap
// - config bits 4..3 pick clock range, 00 meaning power save
// - config bits 2..0 set latency 0.5 to 3.0 clocks in halves
// - continuous burst steps two bytes per word, wraps 7FFFE to zero
// - wrap burst returns to first word of the aligned block
// - latency counts from first falling edge after address as zero
`timescale 1ns/1ps
module quad_ddr_flash_read
  import quad_ddr_flash_read_pkg::*;
(
  input  wire logic                                   ref_clk,
  input  wire logic                                   sys_rst,
  input  wire logic                                   sclk,
  input  wire logic                                   cs_n,
  input  wire logic [quad_ddr_flash_read_pkg::NIB_W-1:0]   data_io_in,
  output logic      [quad_ddr_flash_read_pkg::NIB_W-1:0]   data_io_out,
  output logic      [quad_ddr_flash_read_pkg::NIB_W-1:0]   data_io_oe,
  output logic      [quad_ddr_flash_read_pkg::WADDR_W-1:0] mem_addr,
  input  wire logic [quad_ddr_flash_read_pkg::WORD_W-1:0]  mem_data,
  output logic                                       quad_ddr_read_mode,
  output logic      [7:0]                             quad_read_config,
  output logic                                       power_save
);
  import quad_ddr_flash_read_pkg::*;

  // two-flop synchronisers; third stage only for edge detection
  logic              sclk_s1_reg;
  logic              sclk_s2_reg;
  logic              sclk_s3_reg;
  logic              cs_s1_reg;
  logic              cs_s2_reg;
  logic              cs_s3_reg;
  logic [NIB_W-1:0]  din_s1_reg;
  logic [NIB_W-1:0]  din_s2_reg;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      cs_s3_reg   <= 1'b1;
      din_s1_reg  <= '0;
      din_s2_reg  <= '0;
    end else begin
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg   <= cs_n;
      cs_s2_reg   <= cs_s1_reg;
      cs_s3_reg   <= cs_s2_reg;
      din_s1_reg  <= data_io_in;
      din_s2_reg  <= din_s1_reg;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic sck_edge;
  logic cs_rise;
  logic cs_fall;
  logic selected;
  assign sck_rise = sclk_s2_reg & ~sclk_s3_reg;
  assign sck_fall = ~sclk_s2_reg & sclk_s3_reg;
  assign sck_edge = sck_rise | sck_fall;
  assign cs_rise  = cs_s2_reg & ~cs_s3_reg;
  assign cs_fall  = ~cs_s2_reg & cs_s3_reg;
  assign selected = ~cs_s2_reg;

  mode_state_t               state_reg;
  logic [4:0]                cmd_cnt_reg;
  logic [CMD_BITS-1:0]       cmd_shift_reg;
  logic [2:0]                addr_cnt_reg;
  logic [ADDR_TOP_BIT:0]     addr_shift_reg;
  logic [2:0]                lat_cnt_reg;
  logic [1:0]                nib_idx_reg;
  logic [WORD_W-1:0]         word_reg;
  logic                      release_pend_reg;
  logic [7:0]                config_reg;

  logic [2:0]                burst_field;
  logic [1:0]                clock_range_field;
  logic [2:0]                latency_field;
  assign burst_field       = config_reg[BURST_HI:BURST_LO];
  assign clock_range_field = config_reg[RANGE_HI:RANGE_LO];
  assign latency_field     = config_reg[LAT_HI:LAT_LO];

  logic entry_ok;
  assign entry_ok = (cmd_cnt_reg == 5'(CMD_BITS))
                 && (cmd_shift_reg[CMD_BITS-1:8] == ENTRY_OPCODE);

  // last address nibble arrives on this edge
  logic addr_last;
  assign addr_last = selected && sck_edge && addr_cnt_reg == 3'(ADDR_NIBBLES - 1);
  logic lat_done;
  assign lat_done = lat_cnt_reg == latency_field || lat_cnt_reg == LAT_MAX_CODE;

  // word address of the next word under the selected burst type
  logic [WADDR_W-1:0] wrap_mask;
  logic [WADDR_W-1:0] next_addr;
  logic [WADDR_W-1:0] addr_inc;
  always_comb begin
    wrap_mask = '0;
    case (burst_field)
      BURST_WRAP4:  wrap_mask = WADDR_W'(18'h00003);
      BURST_WRAP8:  wrap_mask = WADDR_W'(18'h00007);
      BURST_WRAP16: wrap_mask = WADDR_W'(18'h0000F);
      BURST_WRAP32: wrap_mask = WADDR_W'(18'h0001F);
      default:      wrap_mask = '0;
    endcase
    addr_inc = mem_addr + WADDR_W'(1);
    // undefined codes 001..011 run on like continuous rather than stall
    if (wrap_mask == '0) begin
      next_addr = addr_inc;
    end else begin
      next_addr = (mem_addr & ~wrap_mask) | (addr_inc & wrap_mask);
    end
  end

  // address as it stands after the nibble arriving this edge
  logic [ADDR_TOP_BIT:0] addr_full;
  assign addr_full = {addr_shift_reg[ADDR_TOP_BIT-NIB_W:0], din_s2_reg};

  // mode and transfer sequencing
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg        <= ST_NORMAL;
      cmd_cnt_reg      <= '0;
      cmd_shift_reg    <= '0;
      addr_cnt_reg     <= '0;
      addr_shift_reg   <= '0;
      lat_cnt_reg      <= '0;
      release_pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_NORMAL: begin
          // only rising edges count, so mode 0 and mode 3 both work
          if (cs_fall) begin
            cmd_cnt_reg <= '0;
          end else if (selected && sck_rise && cmd_cnt_reg != CMD_CNT_MAX) begin
            cmd_shift_reg <= {cmd_shift_reg[CMD_BITS-2:0], din_s2_reg[0]};
            cmd_cnt_reg   <= cmd_cnt_reg + 5'(1);
          end
          if (cs_rise && entry_ok) begin
            state_reg    <= ST_Q_ADDR;
            addr_cnt_reg <= '0;
          end
        end
        default: begin
          if (!selected) begin
            // pause: fresh address phase on the next select
            addr_cnt_reg <= '0;
            lat_cnt_reg  <= '0;
            if (cs_rise && release_pend_reg) begin
              state_reg   <= ST_NORMAL;
              cmd_cnt_reg <= '0;
            end else begin
              state_reg <= ST_Q_ADDR;
            end
            release_pend_reg <= 1'b0;
          end else begin
            case (state_reg)
              ST_Q_ADDR: begin
                if (sck_edge) begin
                  addr_shift_reg <= addr_full;
                  addr_cnt_reg   <= addr_cnt_reg + 3'(1);
                  if (addr_cnt_reg == 3'(ADDR_NIBBLES - 1)) begin
                    state_reg        <= ST_Q_WAIT;
                    release_pend_reg <= (addr_full[15:0] == RELEASE_PATTERN);
                  end
                end
              end
              ST_Q_WAIT: begin
                if (sck_fall) begin
                  state_reg   <= ST_Q_LAT;
                  lat_cnt_reg <= '0;
                end
              end
              ST_Q_LAT: begin
                if (sck_edge) begin
                  if (lat_cnt_reg == latency_field || lat_cnt_reg == LAT_MAX_CODE) begin
                    state_reg <= ST_Q_DATA;
                  end else begin
                    lat_cnt_reg <= lat_cnt_reg + 3'(1);
                  end
                end
              end
              ST_Q_DATA: state_reg <= ST_Q_DATA;
              default:   state_reg <= ST_Q_ADDR;
            endcase
          end
        end
      endcase
    end
  end

  // configuration byte: loaded at entry, held through pauses
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_reg <= CONFIG_RESET;
    end else if (state_reg == ST_NORMAL && cs_rise && entry_ok) begin
      config_reg <= cmd_shift_reg[7:0];
    end
  end

  // output edge: first data edge is the one closing the latency count
  logic out_edge;
  logic first_edge;
  assign first_edge = selected && state_reg == ST_Q_LAT && sck_edge && lat_done;
  assign out_edge   = first_edge || (selected && state_reg == ST_Q_DATA && sck_edge);

  // word address: loaded by the address phase, stepped after each word
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_addr <= '0;
    end else if (state_reg == ST_Q_ADDR && addr_last) begin
      // bits 23..19 and 0 dropped: even byte addresses only
      mem_addr <= addr_full[WADDR_HI_BIT:WADDR_LO_BIT];
    end else if (out_edge && nib_idx_reg == LAST_NIBBLE) begin
      mem_addr <= next_addr;
    end
  end

  // nibble position within the current word
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nib_idx_reg <= '0;
    end else if (state_reg == ST_Q_ADDR && addr_last) begin
      nib_idx_reg <= '0;
    end else if (out_edge) begin
      nib_idx_reg <= nib_idx_reg + 2'(1);
    end
  end

  // word held so its later nibbles survive the address step
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_reg <= '0;
    end else if (out_edge && nib_idx_reg == 2'h0) begin
      word_reg <= mem_data;
    end
  end

  // pin drivers: lines driven only while selected and streaming
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_io_out <= '0;
      data_io_oe  <= '0;
    end else if (!selected || state_reg == ST_NORMAL) begin
      data_io_oe  <= '0;
    end else if (out_edge) begin
      data_io_oe <= '1;
      case (nib_idx_reg)
        2'h0:    data_io_out <= mem_data[15:12];
        2'h1:    data_io_out <= word_reg[11:8];
        2'h2:    data_io_out <= word_reg[7:4];
        default: data_io_out <= word_reg[3:0];
      endcase
    end
  end

  // mode flag lags the state by one cycle so the pin stays glitch free
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      quad_ddr_read_mode <= 1'b0;
    end else begin
      quad_ddr_read_mode <= (state_reg != ST_NORMAL);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      quad_read_config <= CONFIG_RESET;
    end else begin
      quad_read_config <= config_reg;
    end
  end

  // power save only means something while quad mode is active
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_save <= 1'b0;
    end else begin
      power_save <= (state_reg != ST_NORMAL) && (clock_range_field == RANGE_POWER_SAVE);
    end
  end
endmodule : quad_ddr_flash_read

// ===== sim/quad_ddr_flash_read_properties.sv
// port checks for the quad double-rate read block
`timescale 1ns/1ps
module quad_ddr_flash_read_properties
  import quad_ddr_flash_read_pkg::*;
(
  input wire logic                                        ref_clk,
  input wire logic                                        sys_rst,
  input wire logic                                        cs_n,
  input wire logic [quad_ddr_flash_read_pkg::NIB_W-1:0]   data_io_oe,
  input wire logic [quad_ddr_flash_read_pkg::WADDR_W-1:0] mem_addr,
  input wire logic                                        quad_ddr_read_mode,
  input wire logic [7:0]                                  quad_read_config,
  input wire logic                                        power_save
);
  logic [WADDR_W-1:0] wrap_mask;
  // wrap bursts keep the block base; continuous spans the array
  assign wrap_mask = quad_read_config[BURST_HI] ? (18'h4 << quad_read_config[6:5]) - 18'h1 : '1;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  a_oe_lines_equal: assert property (data_io_oe == 4'h0 || data_io_oe == 4'hF)
    else $error("line enables differ");
  a_oe_only_quad: assert property (data_io_oe != 4'h0 |-> quad_ddr_read_mode)
    else $error("lines driven outside quad mode");
  a_oe_float_deselect: assert property ($rose(cs_n) |-> ##[1:6] data_io_oe == 4'h0)
    else $error("lines driven after deselect");
  a_oe_rise_selected: assert property ($rose(data_io_oe[0]) |-> !$past(cs_n, 3))
    else $error("lines driven while deselected");
  a_mode_on_deselect: assert property ($changed(quad_ddr_read_mode) |-> cs_n && $past(cs_n, 3))
    else $error("mode changed while selected");
  a_config_held: assert property (quad_ddr_read_mode && $past(quad_ddr_read_mode) |-> $stable(quad_read_config))
    else $error("config changed in quad mode");
  a_power_save_range: assert property (power_save |-> quad_read_config[RANGE_HI:RANGE_LO] == RANGE_POWER_SAVE)
    else $error("power save in fast range");
  a_burst_next: assert property (!$past(cs_n, 2) && $past(data_io_oe[0]) && $changed(mem_addr)
    |-> mem_addr == ((($past(mem_addr) + 18'h1) & wrap_mask) | ($past(mem_addr) & ~wrap_mask)))
    else $error("burst address step wrong");
endmodule : quad_ddr_flash_read_properties
bind quad_ddr_flash_read quad_ddr_flash_read_properties i_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .cs_n(cs_n), .data_io_oe(data_io_oe), .mem_addr(mem_addr), .quad_ddr_read_mode(quad_ddr_read_mode),
  .quad_read_config(quad_read_config), .power_save(power_save));

// ===== sim/quad_host_model.sv
// host controller model: select, serial clock and the four data lines
`timescale 1ns/1ps
module quad_host_model (
  input  wire logic       ref_clk,
  input  wire logic [3:0] data_io_out,
  input  wire logic [3:0] data_io_oe,
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      data_io_in
);
  logic [3:0]  drv = 4'h0;
  logic        hoe = 1'b1;
  logic        junk = 1'b0;
  logic [15:0] w;
  logic [15:0] got [0:32];
  // released lines toggle so a stale level never reads as data
  always @(posedge ref_clk) junk <= ~junk;
  assign data_io_in = data_io_oe[0] ? data_io_out : hoe ? drv : {4{junk}};
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  task automatic edge_at(input logic [3:0] d);
    #150 drv = d;
    #50 sclk = ~sclk;
  endtask : edge_at
  task automatic cmd(input logic [15:0] bits, input int n, input logic m3);
    sclk = m3;
    #200 cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      edge_at({3'h0, bits[i]});
      edge_at({3'h0, bits[i]});
    end
    #200 cs_n = 1'b1;
    #200 sclk = 1'b0;
    #2000;
  endtask : cmd
  task automatic rd(input logic [23:0] a, input int lat, input int nw);
    int e;
    int k;
    e = 0;
    k = 0;
    cs_n = 1'b0;
    for (int i = 5; i >= 0; i--) edge_at(a[i*4 +: 4]);
    #150 hoe = 1'b0;
    #50;
    while (k < nw * 4) begin
      sclk = ~sclk;
      e++;
      // sample the previous edge's nibble, well after it settles
      #50;
      if (e > 3 + lat) begin
        w = {w[11:0], data_io_in};
        if (k % 4 == 3) got[k / 4] = w;
        k++;
      end
      #150;
    end
    cs_n = 1'b1;
    hoe = 1'b1;
    #200 sclk = 1'b0;
    #2000;
  endtask : rd
endmodule : quad_host_model

// ===== sim/test_quad_ddr_flash_read.sv
// self-checking bench for the quad double-rate read block
`timescale 1ns/1ps
module test_quad_ddr_flash_read;
  import quad_ddr_flash_read_pkg::*;
  logic               ref_clk, sclk, cs_n, quad_ddr_read_mode, power_save;
  logic               sys_rst = 1'b1;
  logic [NIB_W-1:0]   data_io_in, data_io_out, data_io_oe;
  logic [WADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0]  mem_data;
  logic [7:0]         quad_read_config;
  int                 bad_count = 0, check_count = 0, cycles = 0;
  // array word is a fixed scramble of its address
  assign mem_data = mem_addr[15:0] ^ 16'h3C5A;
  quad_ddr_flash_read i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
    .data_io_in(data_io_in), .data_io_out(data_io_out), .data_io_oe(data_io_oe), .mem_addr(mem_addr),
    .mem_data(mem_data), .quad_ddr_read_mode(quad_ddr_read_mode), .quad_read_config(quad_read_config),
    .power_save(power_save));
  quad_host_model i_host (.ref_clk(ref_clk), .data_io_out(data_io_out), .data_io_oe(data_io_oe),
    .sclk(sclk), .cs_n(cs_n), .data_io_in(data_io_in));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // whole run needs well under 10000 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [17:0] word_at(input logic [17:0] wa);
    return {2'h0, wa[15:0] ^ 16'h3C5A};
  endfunction : word_at
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic t_entry();
    chk(18'(quad_read_config), 18'(CONFIG_RESET));
    i_host.cmd({8'hD5, 8'h00}, 16, 1'b0);
    chk(18'(quad_ddr_read_mode), 18'h0);
    i_host.cmd({ENTRY_OPCODE, 8'h00}, 15, 1'b0);
    chk(18'(quad_ddr_read_mode), 18'h0);
    i_host.cmd({ENTRY_OPCODE, 8'h00}, 16, 1'b0);
    chk(18'(quad_ddr_read_mode), 18'h1);
    chk(18'(power_save), 18'h1);
    $display("entry test done");
  endtask : t_entry
  task automatic t_cont();
    i_host.rd(24'h77FFFC, 0, 4);
    for (int i = 0; i < 4; i++) chk(18'(i_host.got[i]), word_at(18'h3FFFE + 18'(i)));
    chk(18'(data_io_oe), 18'h0);
    i_host.rd(24'h000100, 0, 2);
    for (int i = 0; i < 2; i++) chk(18'(i_host.got[i]), word_at(18'h80 + 18'(i)));
    $display("continuous test done");
  endtask : t_cont
  task automatic t_wrap();
    logic [7:0] cfg;
    int         n;
    int         lat;
    for (int b = 4; b < 8; b++) begin
      n = 4 << (b - 4);
      lat = (b == 7) ? 5 : b - 3;
      cfg = {3'(b), 2'h2, 3'(lat)};
      i_host.rd({8'h43, RELEASE_PATTERN}, 0, 0);
      chk(18'(quad_ddr_read_mode), 18'h0);
      i_host.cmd({ENTRY_OPCODE, cfg}, 16, b[0]);
      chk(18'(quad_read_config), 18'(cfg));
      chk(18'(power_save), 18'h0);
      i_host.rd(24'h000086, lat, n + 1);
      for (int i = 0; i <= n; i++) chk(18'(i_host.got[i]), word_at(18'h40 | ((18'h3 + 18'(i)) & 18'(n - 1))));
    end
    $display("wrap test done");
  endtask : t_wrap
  // burst code 001 runs on past a block edge; latency code 7 acts as 5
  task automatic t_odd();
    i_host.rd({8'h03, RELEASE_PATTERN}, 0, 0);
    chk(18'(quad_ddr_read_mode), 18'h0);
    i_host.cmd({ENTRY_OPCODE, 8'h2F}, 16, 1'b1);
    chk(18'(quad_read_config), 18'h2F);
    chk(18'(power_save), 18'h0);
    i_host.rd(24'h0000FC, 5, 4);
    for (int i = 0; i < 4; i++) chk(18'(i_host.got[i]), word_at(18'h7E + 18'(i)));
    $display("odd code test done");
  endtask : t_odd
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    t_entry();
    t_cont();
    t_wrap();
    t_odd();
    close_out();
  end
endmodule : test_quad_ddr_flash_read
